// ### logic/vphy_an_consts.svh
// constants for the virtual phy ability register pair
`ifndef VPHY_AN_CONSTS_SVH
`define VPHY_AN_CONSTS_SVH

// byte offsets on the 32-bit register map
`define ADV_OFFSET 12'h1d0
`define LP_OFFSET 12'h1d4

// register indices for serial management access
`define ADV_INDEX 5'h04
`define LP_INDEX 5'h05

// bit positions within the 16-bit register
`define NP_BIT 15
`define ACK_BIT 14
`define RF_BIT 13
`define ASYM_BIT 11
`define SYM_BIT 10
`define T4_BIT 9
`define SPEED_HI 8
`define SPEED_LO 5
`define SEL_HI 4

// reset and fixed values
`define SEL_8023 5'h01
`define ADV_SPEED_RST 4'hf
`define PAUSE_RST 2'h0

// emulated partner speed/duplex codes, bits 8..5
`define LP_FD10 4'h2
`define LP_FD100 4'h8
`define LP_HD10 4'h1
`define LP_HD100 4'h4

// cycles to wait after reset until the strap synchroniser has settled
`define STRAP_SETTLE 3'h4

`endif

// ### logic/vphy_an_pkg.sv
// types shared by the virtual phy ability register design
package vphy_an_pkg;

  typedef enum logic [1:0] {PH_INIT, PH_NEG, PH_DONE} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [2:0] settle;
    logic [1:0] adv_pause;   // {asym, sym}
    logic [3:0] adv_speed;
    logic [4:0] adv_sel;
    logic [1:0] lp_pause;    // {asym, sym}
    logic [3:0] lp_speed;
    logic an_done;
    logic an_fail;
    logic [31:0] rdata;
    logic rvalid;
    logic [15:0] mdata;
    logic mvalid;
  } vphy_state_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] stable;
  } strap_sync_t;

endpackage : vphy_an_pkg

// ### logic/strap_sync.sv
// three-stage synchroniser for the configuration strap pins
`timescale 1ns/1ps
module strap_sync import vphy_an_pkg::*; (
  input wire logic clk_sys,          // system clock
  input wire logic resetn,           // synchronous reset, active low
  input wire logic ce,               // clock enable, freezes state when low
  input wire logic [3:0] pins_async, // raw strap pins
  output logic [3:0] pins_stable     // agreed strap levels
);

  strap_sync_t sy_q;
  strap_sync_t sy_d;

  always_comb begin
    sy_d = sy_q;
    sy_d.s1 = pins_async;
    sy_d.s2 = sy_q.s1;
    sy_d.s3 = sy_q.s2;
    // a level is accepted only once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      if (sy_q.s2[i] == sy_q.s3[i]) begin
        sy_d.stable[i] = sy_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sy_q <= '0;
    end else if (ce) begin
      sy_q <= sy_d;
    end
  end

  assign pins_stable = sy_q.stable;

endmodule : strap_sync

// ### logic/vphy_an_regs.sv
// auto-negotiation advertisement and emulated partner ability registers
`timescale 1ns/1ps
`include "vphy_an_consts.svh"
module vphy_an_regs import vphy_an_pkg::*; (
  input wire logic clk_sys,                 // 10 MHz system clock
  input wire logic resetn,                  // synchronous reset, active low
  input wire logic ce,                      // clock enable, freezes all state
  input wire logic reg_rd,                  // register map read strobe
  input wire logic reg_wr,                  // register map write strobe
  input wire logic [11:0] reg_addr,         // register map byte address
  input wire logic [31:0] reg_wdata,        // register map write data
  output logic [31:0] reg_rdata,            // register map read data
  output logic reg_rvalid,                  // read data valid pulse
  input wire logic mgmt_rd,                 // management read strobe
  input wire logic mgmt_wr,                 // management write strobe
  input wire logic [4:0] mgmt_index,        // management register index
  input wire logic [15:0] mgmt_wdata,       // management write data
  output logic [15:0] mgmt_rdata,           // management read data
  output logic mgmt_rvalid,                 // management read valid pulse
  input wire logic an_restart,              // re-run negotiation pulse
  input wire logic forced_pause_select_pin, // manual flow-control strap
  input wire logic full_duplex_pause_pin,   // full-duplex flow-control strap
  input wire logic duplex_strap_pin,        // duplex strap, 1 = full
  input wire logic speed_strap_pin,         // speed strap, 1 = 100
  output logic an_complete,                 // negotiation complete level
  output logic an_failed                    // no common ability found
);

  localparam vphy_state_t ST_RST = '{
    phase: PH_INIT,
    adv_pause: `PAUSE_RST,
    adv_speed: `ADV_SPEED_RST,
    adv_sel: `SEL_8023,
    default: '0
  };

  vphy_state_t st_q;
  vphy_state_t st_d;
  logic [3:0] strap_q;
  logic adv_reg_wr;
  logic adv_mgmt_wr;

  strap_sync i_strap_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .pins_async({speed_strap_pin, duplex_strap_pin, full_duplex_pause_pin,
                 forced_pause_select_pin}),
    .pins_stable(strap_q)
  );

  // partner pause, {asym, sym}, as the partner always accommodates us
  function automatic logic [1:0] pause_resolve(input logic [1:0] adv, input logic fd_fc);
    logic [1:0] r;
    r = 2'h0;
    unique case (adv)
      2'h0: r = 2'h0;
      2'h1: r = 2'h1;
      2'h2: r = 2'h3;
      2'h3: r = fd_fc ? 2'h3 : 2'h2;
    endcase
    return r;
  endfunction : pause_resolve

  function automatic logic [3:0] speed_map(input logic full, input logic fast);
    logic [3:0] r;
    r = 4'h0;
    unique case ({full, fast})
      2'h2: r = `LP_FD10;
      2'h3: r = `LP_FD100;
      2'h0: r = `LP_HD10;
      2'h1: r = `LP_HD100;
    endcase
    return r;
  endfunction : speed_map

  // 16-bit view shared by the register map and the management path
  function automatic logic [15:0] view_word(input logic is_adv, input logic is_lp,
                                            input vphy_state_t s);
    logic [15:0] w;
    w = 16'h0;
    if (is_adv) begin
      w[`ASYM_BIT] = s.adv_pause[1];
      w[`SYM_BIT] = s.adv_pause[0];
      w[`SPEED_HI:`SPEED_LO] = s.adv_speed;
      w[`SEL_HI:0] = s.adv_sel;
    end else if (is_lp) begin
      w[`ACK_BIT] = 1'b1;
      w[`ASYM_BIT] = s.lp_pause[1];
      w[`SYM_BIT] = s.lp_pause[0];
      w[`SPEED_HI:`SPEED_LO] = s.lp_speed;
      w[`SEL_HI:0] = `SEL_8023;
    end
    // next page, remote fault and T4 stay zero in both words
    return w;
  endfunction : view_word

  assign adv_reg_wr = reg_wr && (reg_addr == `ADV_OFFSET);
  assign adv_mgmt_wr = mgmt_wr && (mgmt_index == `ADV_INDEX);

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.mvalid = 1'b0;
    unique case (st_q.phase)
      PH_INIT: begin
        // straps are only trusted once the synchroniser has filled
        if (st_q.settle == `STRAP_SETTLE) begin
          st_d.adv_pause = {2{~strap_q[0]}};
          st_d.phase = PH_NEG;
        end else begin
          st_d.settle = st_q.settle + 3'h1;
        end
      end
      PH_NEG: begin
        st_d.lp_pause = pause_resolve(st_q.adv_pause, strap_q[1]);
        st_d.lp_speed = speed_map(strap_q[2], strap_q[3]);
        st_d.an_fail = (st_q.adv_speed & speed_map(strap_q[2], strap_q[3])) == 4'h0;
        st_d.an_done = 1'b1;
        st_d.phase = PH_DONE;
      end
      PH_DONE: begin
        // later advertisement edits take effect only after a restart
        if (an_restart) begin
          st_d.an_done = 1'b0;
          st_d.phase = PH_NEG;
        end
      end
      default: begin
        st_d.phase = PH_INIT;
      end
    endcase
    // writes touch only writable fields; the partner word has none
    if (adv_mgmt_wr) begin
      st_d.adv_pause = mgmt_wdata[`ASYM_BIT:`SYM_BIT];
      st_d.adv_speed = mgmt_wdata[`SPEED_HI:`SPEED_LO];
      st_d.adv_sel = mgmt_wdata[`SEL_HI:0];
    end
    // the register map wins when both paths write in one cycle
    if (adv_reg_wr) begin
      st_d.adv_pause = reg_wdata[`ASYM_BIT:`SYM_BIT];
      st_d.adv_speed = reg_wdata[`SPEED_HI:`SPEED_LO];
      st_d.adv_sel = reg_wdata[`SEL_HI:0];
    end
    if (reg_rd) begin
      st_d.rdata = {16'h0, view_word(reg_addr == `ADV_OFFSET,
                                     reg_addr == `LP_OFFSET, st_q)};
      st_d.rvalid = 1'b1;
    end
    if (mgmt_rd) begin
      st_d.mdata = view_word(mgmt_index == `ADV_INDEX,
                             mgmt_index == `LP_INDEX, st_q);
      st_d.mvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= ST_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign mgmt_rdata = st_q.mdata;
  assign mgmt_rvalid = st_q.mvalid;
  assign an_complete = st_q.an_done;
  assign an_failed = st_q.an_fail;

  a_upper_pad_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    reg_rvalid |-> reg_rdata[31:16] == 16'h0)
    else $error("upper half of register word not zero");

  a_adv_fixed_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && reg_rd && reg_addr == `ADV_OFFSET |=>
      reg_rdata[`NP_BIT] == 1'b0 && reg_rdata[`RF_BIT] == 1'b0 && reg_rdata[`T4_BIT] == 1'b0)
    else $error("fixed advertisement bits not zero");

  a_adv_pause_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && adv_reg_wr |=> st_q.adv_pause == $past(reg_wdata[`ASYM_BIT:`SYM_BIT]))
    else $error("advertised pause write not stored");

  a_pause_strap_load: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_INIT && st_q.settle == `STRAP_SETTLE &&
      !adv_reg_wr && !adv_mgmt_wr |=> st_q.adv_pause == {2{~$past(strap_q[0])}})
    else $error("pause bits not loaded from strap");

  a_adv_reset_value: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !$past(resetn) |-> st_q.adv_speed == `ADV_SPEED_RST && st_q.adv_sel == `SEL_8023)
    else $error("advertisement reset value wrong");

  a_lp_fixed_bits: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && reg_rd && reg_addr == `LP_OFFSET |=>
      reg_rdata[15:12] == 4'h4 && reg_rdata[`T4_BIT] == 1'b0 &&
      reg_rdata[`SEL_HI:0] == `SEL_8023)
    else $error("partner fixed bits wrong");

  a_lp_view_match: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && reg_rd && reg_addr == `LP_OFFSET |=>
      reg_rdata[11:5] == {$past(st_q.lp_pause), 1'b0, $past(st_q.lp_speed)})
    else $error("partner pause or speed view wrong");

  a_lp_pause_both: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && st_q.adv_pause == 2'h3 |=>
      st_q.lp_pause == ($past(strap_q[1]) ? 2'h3 : 2'h2))
    else $error("partner pause for both advertised wrong");

  a_lp_pause_sym: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && st_q.adv_pause == 2'h1 |=> st_q.lp_pause == 2'h1)
    else $error("partner pause for symmetric only wrong");

  a_lp_speed_strap: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && strap_q[3:2] == 2'h3 |=> st_q.lp_speed == 4'h8)
    else $error("partner speed for full 100 wrong");

  a_lp_pause_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_q.phase == PH_DONE && $past(st_q.phase) == PH_DONE |-> $stable(st_q.lp_pause))
    else $error("partner pause changed without negotiation");

  a_lp_write_ignored: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && reg_wr && reg_addr == `LP_OFFSET && st_q.phase == PH_DONE && !an_restart |=>
      $stable(st_q.lp_pause) && $stable(st_q.lp_speed))
    else $error("write to partner register took effect");

  a_ce_freeze: assert property ( // clock enable
    @(posedge clk_sys) disable iff (!resetn)
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

  // read strobes answer in exactly one enabled cycle on both paths
  a_reg_rvalid_pulse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce |=> reg_rvalid == $past(reg_rd))
    else $error("register map read valid not a single pulse");

  a_mgmt_rvalid_pulse: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce |=> mgmt_rvalid == $past(mgmt_rd))
    else $error("management read valid not a single pulse");

  a_unmapped_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && reg_rd && reg_addr != `ADV_OFFSET && reg_addr != `LP_OFFSET |=>
      reg_rdata == 32'h00000000)
    else $error("unmapped address did not read zero");

  a_mgmt_adv_fixed: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && mgmt_rd && mgmt_index == `ADV_INDEX |=>
      mgmt_rdata[15:12] == 4'h0 && mgmt_rdata[`T4_BIT] == 1'b0)
    else $error("fixed management advertisement bits not zero");

  a_mgmt_lp_fixed: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && mgmt_rd && mgmt_index == `LP_INDEX |=>
      mgmt_rdata[15:12] == 4'h4 && mgmt_rdata[`T4_BIT] == 1'b0 &&
      mgmt_rdata[`SEL_HI:0] == `SEL_8023)
    else $error("fixed management partner bits wrong");

  a_adv_mgmt_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && adv_mgmt_wr && !adv_reg_wr |=>
      st_q.adv_pause == $past(mgmt_wdata[`ASYM_BIT:`SYM_BIT]) &&
      st_q.adv_speed == $past(mgmt_wdata[`SPEED_HI:`SPEED_LO]))
    else $error("management advertisement write not stored");

  a_adv_speed_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && adv_reg_wr |=>
      st_q.adv_speed == $past(reg_wdata[`SPEED_HI:`SPEED_LO]) &&
      st_q.adv_sel == $past(reg_wdata[`SEL_HI:0]))
    else $error("advertised speed or selector write not stored");

  a_lp_pause_asym: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && st_q.adv_pause == 2'h2 |=> st_q.lp_pause == 2'h3)
    else $error("partner pause for asymmetric only wrong");

  a_lp_pause_none: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && st_q.adv_pause == 2'h0 |=> st_q.lp_pause == 2'h0)
    else $error("partner pause for none advertised wrong");

  // the remaining strap codes, so every row of the partner speed table is guarded
  a_lp_speed_full10: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && strap_q[3:2] == 2'h1 |=> st_q.lp_speed == 4'h2)
    else $error("partner speed for full 10 wrong");

  a_lp_speed_half10: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && strap_q[3:2] == 2'h0 |=> st_q.lp_speed == 4'h1)
    else $error("partner speed for half 10 wrong");

  a_lp_speed_half100: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG && strap_q[3:2] == 2'h2 |=> st_q.lp_speed == 4'h4)
    else $error("partner speed for half 100 wrong");

  a_neg_complete: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_NEG |=> an_complete)
    else $error("negotiation did not complete");

  a_restart_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ce && st_q.phase == PH_DONE && an_restart |=> !an_complete)
    else $error("restart did not clear completion");

endmodule : vphy_an_regs

// ### testbench/mgmt_host.sv
// host model that issues register-map and management accesses
`timescale 1ns/1ps
module mgmt_host (
  input wire logic clk_sys, // system clock
  output logic reg_rd, // map read strobe
  output logic reg_wr, // map write strobe
  output logic [11:0] reg_addr, // map byte address
  output logic [31:0] reg_wdata, // map write data
  input wire logic [31:0] reg_rdata, // map read data
  input wire logic reg_rvalid, // map read valid
  output logic mgmt_rd, // management read strobe
  output logic mgmt_wr, // management write strobe
  output logic [4:0] mgmt_index, // management index
  output logic [15:0] mgmt_wdata, // management write data
  input wire logic [15:0] mgmt_rdata, // management read data
  input wire logic mgmt_rvalid // management read valid
);
  initial begin
    {reg_rd, reg_wr, mgmt_rd, mgmt_wr} = 4'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
    mgmt_index = 5'h00;
    mgmt_wdata = 16'h0000;
  end

  // idle address and data lines show the inverse of the last value, so stale data never helps
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : reg_write

  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    d = 'x;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge clk_sys);
    end
  endtask : reg_read

  task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_wr <= 1'b1;
    mgmt_index <= a;
    mgmt_wdata <= d;
    @(posedge clk_sys);
    mgmt_wr <= 1'b0;
    mgmt_index <= ~a;
    mgmt_wdata <= ~d;
  endtask : mgmt_write

  task automatic mgmt_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    mgmt_rd <= 1'b1;
    mgmt_index <= a;
    @(posedge clk_sys);
    mgmt_rd <= 1'b0;
    mgmt_index <= ~a;
    d = 'x;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (mgmt_rvalid === 1'b1) begin
        d = mgmt_rdata;
        break;
      end
      @(posedge clk_sys);
    end
  endtask : mgmt_read
endmodule : mgmt_host

// ### testbench/tb_top.sv
// self-checking bench for the ability register pair
`timescale 1ns/1ps
`include "vphy_an_consts.svh"
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t %s", $time, m); end end
module tb_top;
  logic clk_sys, resetn, ce, an_restart, an_complete, an_failed;
  logic fpause, fdpause, dup, spd, reg_rd, reg_wr, reg_rvalid, mgmt_rd, mgmt_wr, mgmt_rvalid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, w;
  logic [4:0] mgmt_index;
  logic [15:0] mgmt_wdata, mgmt_rdata, h;
  int n_fail = 0;
  int num_checks = 0;

  vphy_an_regs i_vphy_an_regs (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_index(mgmt_index),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .an_restart(an_restart), .forced_pause_select_pin(fpause), .full_duplex_pause_pin(fdpause),
    .duplex_strap_pin(dup), .speed_strap_pin(spd), .an_complete(an_complete),
    .an_failed(an_failed));
  mgmt_host i_mgmt_host (.clk_sys(clk_sys), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // pause is {asym, sym}; software keeps the selector at the 802.3 code
  function automatic logic [15:0] adv_word(input logic [1:0] p, input logic [3:0] s);
    return {4'h0, p, 1'b0, s, 5'h01};
  endfunction : adv_word

  function automatic logic [15:0] lp_word(input logic [1:0] p, input logic f, input logic d,
                                          input logic s);
    logic [1:0] q;
    logic [3:0] sp;
    q = (p == 2'h1) ? 2'h1 : (p == 2'h2) ? 2'h3 : (p == 2'h3) ? (f ? 2'h3 : 2'h2) : 2'h0;
    sp = d ? (s ? 4'h8 : 4'h2) : (s ? 4'h4 : 4'h1);
    return {4'h4, q, 1'b0, sp, 5'h01};
  endfunction : lp_word

  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic fp);
    @(posedge clk_sys);
    resetn <= 1'b0;
    fpause <= fp;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      #1;
      if (an_complete === 1'b1) break;
    end
    `CHK(an_complete, 1'b1, "no completion after reset")
  endtask : do_reset

  task automatic renegotiate();
    @(posedge clk_sys);
    an_restart <= 1'b1;
    @(posedge clk_sys);
    an_restart <= 1'b0;
    #1;
    `CHK(an_complete, 1'b0, "restart not taken")
    @(posedge clk_sys);
    #1;
    `CHK(an_complete, 1'b1, "renegotiation late")
  endtask : renegotiate

  task automatic t_defaults();
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, {16'h0, adv_word(2'h3, 4'hf)}, "advert reset")
    i_mgmt_host.mgmt_read(`ADV_INDEX, h);
    `CHK(h, adv_word(2'h3, 4'hf), "advert via mgmt")
    i_mgmt_host.reg_read(`LP_OFFSET, w);
    `CHK(w, {16'h0, lp_word(2'h3, 1'b1, 1'b1, 1'b1)}, "partner reset")
    `CHK(an_failed, 1'b0, "failed flag")
  endtask : t_defaults

  task automatic t_ro_bits();
    i_mgmt_host.reg_write(`ADV_OFFSET, 32'h00000001);
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, 32'h00000001, "advert clear")
    i_mgmt_host.reg_write(`ADV_OFFSET, 32'hffffffe1);
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, 32'h00000de1, "fixed bits moved")
    i_mgmt_host.reg_write(`LP_OFFSET, 32'h0000b21e);
    i_mgmt_host.reg_read(`LP_OFFSET, w);
    `CHK(w, {16'h0, lp_word(2'h3, 1'b1, 1'b1, 1'b1)}, "partner written")
    i_mgmt_host.reg_read(12'h1e0, w);
    `CHK(w, 32'h00000000, "unmapped read")
  endtask : t_ro_bits

  task automatic t_pause_table();
    logic [15:0] prev;
    prev = lp_word(2'h3, 1'b1, 1'b1, 1'b1);
    for (int f = 0; f < 2; f++) begin
      for (int p = 0; p < 4; p++) begin
        @(posedge clk_sys);
        fdpause <= f[0];
        i_mgmt_host.reg_write(`ADV_OFFSET, {16'h0, adv_word(p[1:0], 4'hf)});
        repeat (8) @(posedge clk_sys);
        i_mgmt_host.mgmt_read(`LP_INDEX, h);
        `CHK(h, prev, "partner moved early")
        renegotiate();
        prev = lp_word(p[1:0], f[0], 1'b1, 1'b1);
        i_mgmt_host.mgmt_read(`LP_INDEX, h);
        `CHK(h, prev, "partner pause")
      end
    end
  endtask : t_pause_table

  task automatic t_speed_table();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      dup <= k[1];
      spd <= k[0];
      repeat (8) @(posedge clk_sys);
      renegotiate();
      i_mgmt_host.reg_read(`LP_OFFSET, w);
      `CHK(w, {16'h0, lp_word(2'h3, 1'b1, k[1], k[0])}, "partner speed")
    end
    i_mgmt_host.mgmt_write(`ADV_INDEX, adv_word(2'h1, 4'h0));
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, {16'h0, adv_word(2'h1, 4'h0)}, "mgmt write")
    renegotiate();
    @(posedge clk_sys);
    #1;
    `CHK(an_failed, 1'b1, "no common ability")
  endtask : t_speed_table

  task automatic t_forced_strap();
    do_reset(1'b1);
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, {16'h0, adv_word(2'h0, 4'hf)}, "forced pause reset")
  endtask : t_forced_strap

  // a write and a restart offered while the enable is low must both be lost
  task automatic t_ce_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    an_restart <= 1'b1;
    i_mgmt_host.reg_write(`ADV_OFFSET, 32'h00000de1);
    an_restart <= 1'b0;
    ce <= 1'b1;
    #1;
    `CHK(an_complete, 1'b1, "restart taken while frozen")
    i_mgmt_host.reg_read(`ADV_OFFSET, w);
    `CHK(w, {16'h0, adv_word(2'h0, 4'hf)}, "write taken while frozen")
  endtask : t_ce_freeze

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end

  initial begin
    {resetn, an_restart, fpause} = 3'h0;
    {ce, fdpause, dup, spd} = 4'hf;
    do_reset(1'b0);
    t_defaults();
    t_ro_bits();
    t_pause_table();
    t_speed_table();
    t_forced_strap();
    t_ce_freeze();
    complete_run();
  end
endmodule : tb_top
